/* hw/eac_pkg.sv */
package eac_pkg;
  // Clock and programming time base
  localparam int CLK_KHZ = 25000;
  localparam int RC_WRITE_CYCLES = 26368;
  localparam int RC_WRITE_TIME_US = 3300;
  localparam int RC_KHZ = RC_WRITE_CYCLES * 1000 / RC_WRITE_TIME_US;
  localparam int ATOMIC_TIME_US = 3400;
  localparam int SPLIT_TIME_US = 1800;
  localparam int ATOMIC_TICKS_DEF = RC_WRITE_CYCLES;
  localparam int SPLIT_TICKS_DEF = RC_WRITE_CYCLES * SPLIT_TIME_US /
                                   ATOMIC_TIME_US;
  localparam logic [15:0] RC_STEP = 16'(RC_KHZ);
  localparam logic [15:0] CLK_WRAP = 16'(CLK_KHZ);
  localparam int TICK_W = 15;

  // CPU stall and arm window lengths, in clock cycles
  localparam logic [2:0] READ_STALL_CYCLES = 3'h4;
  localparam logic [2:0] WRITE_STALL_CYCLES = 3'h2;
  localparam logic [2:0] ARM_WINDOW_CYCLES = 3'h4;

  // Register selects on the I/O port
  localparam logic [1:0] REG_ADDR_LOW = 2'h0;
  localparam logic [1:0] REG_ADDR_HIGH = 2'h1;
  localparam logic [1:0] REG_DATA = 2'h2;
  localparam logic [1:0] REG_CTRL = 2'h3;

  // Control register field positions
  localparam int CTRL_READ_BIT = 0;
  localparam int CTRL_PROG_BIT = 1;
  localparam int CTRL_ARM_BIT = 2;
  localparam int CTRL_IRQEN_BIT = 3;
  localparam int CTRL_MODE_LSB = 4;

  // Address and array geometry
  localparam int ADDR_W = 12;
  localparam int ADDR_HI_W = 4;
  localparam int NV_AW = 10;
  localparam int NV_DEPTH = 1 << NV_AW;

  // Reset and fill values
  localparam logic [11:0] ADDR_RESET = 12'h000;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  typedef enum logic [1:0] {
    MODE_ATOMIC,
    MODE_ERASE,
    MODE_WRITE,
    MODE_RSVD
  } eac_mode_type;

  localparam eac_mode_type MODE_RESET = MODE_ATOMIC;
endpackage : eac_pkg

/* hw/eac_nv_array.sv */
`timescale 1ns/1ps
module eac_nv_array
  import eac_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_commit,
  input wire eac_mode_type i_mode,
  input wire logic [NV_AW-1:0] i_addr,
  input wire logic [7:0] i_data,
  input wire logic [NV_AW-1:0] i_rd_addr,
  output logic [7:0] o_rd_data
);
  // Nonvolatile cells carry no reset on purpose
  logic [7:0] mem [NV_DEPTH];

  // Asynchronous look-up so a read completes within one instruction
  assign o_rd_data = mem[i_rd_addr];

  // Write-only can only clear bits, so it relies on a prior erase
  always_ff @(posedge i_clk) begin
    if (i_commit) begin
      unique case (i_mode)
        MODE_ATOMIC: mem[i_addr] <= i_data;
        MODE_ERASE: mem[i_addr] <= ERASED_BYTE;
        MODE_WRITE: mem[i_addr] <= mem[i_addr] & i_data;
        MODE_RSVD: mem[i_addr] <= mem[i_addr];
      endcase
    end
  end
endmodule : eac_nv_array

/* hw/eac_prog_engine.sv */
`timescale 1ns/1ps
module eac_prog_engine
  import eac_pkg::*;
#(
  parameter int ATOMIC_TICKS = ATOMIC_TICKS_DEF,
  parameter int SPLIT_TICKS = SPLIT_TICKS_DEF
) (
  input wire logic i_clk,
  input wire logic i_por_rst,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic i_mode_wr,
  input wire eac_mode_type i_mode_val,
  input wire logic [NV_AW-1:0] i_addr,
  input wire logic [7:0] i_data,
  output logic o_busy,
  output eac_mode_type o_mode,
  output logic o_commit,
  output eac_mode_type o_commit_mode,
  output logic [NV_AW-1:0] o_commit_addr,
  output logic [7:0] o_commit_data
);
  typedef struct packed {
    logic busy;
    eac_mode_type mode;
    eac_mode_type op;
    logic [15:0] acc;
    logic [TICK_W-1:0] ticks;
    logic [NV_AW-1:0] addr;
    logic [7:0] data;
    logic commit;
  } eac_eng_type;

  eac_eng_type s;
  eac_eng_type next_s;
  logic [15:0] acc_sum;

  // Oscillator cycles for each programming action
  function automatic logic [TICK_W-1:0] mode_ticks(input eac_mode_type m);
    if (m == MODE_ATOMIC) begin
      mode_ticks = TICK_W'(ATOMIC_TICKS);
    end else begin
      mode_ticks = TICK_W'(SPLIT_TICKS);
    end
  endfunction : mode_ticks

  // Mode update, launch and self-timed countdown
  always_comb begin
    next_s = s;
    next_s.commit = 1'b0;
    acc_sum = s.acc + RC_STEP;
    if (i_rst && !s.busy) begin
      next_s.mode = MODE_RESET;
    end else if (i_mode_wr && !s.busy) begin
      next_s.mode = i_mode_val;
    end
    if (s.busy) begin
      if (s.op == MODE_RSVD) begin
        next_s.busy = 1'b0;
      end else if (acc_sum >= CLK_WRAP) begin
        // Fractional divider stands in for the calibrated oscillator
        next_s.acc = acc_sum - CLK_WRAP;
        if (s.ticks <= TICK_W'(1)) begin
          next_s.busy = 1'b0;
          next_s.commit = 1'b1;
        end else begin
          next_s.ticks = s.ticks - TICK_W'(1);
        end
      end else begin
        next_s.acc = acc_sum;
      end
    end else if (i_start) begin
      // Operands are latched so a CPU reset cannot disturb the write
      next_s.busy = 1'b1;
      next_s.op = i_mode_wr ? i_mode_val : s.mode;
      next_s.ticks = mode_ticks(next_s.op);
      next_s.acc = 16'h0000;
      next_s.addr = i_addr;
      next_s.data = i_data;
    end
  end

  // Only power-on clears the engine; CPU reset lets a write finish
  always_ff @(posedge i_clk or posedge i_por_rst) begin
    if (i_por_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_busy = s.busy;
  assign o_mode = s.mode;
  assign o_commit = s.commit;
  assign o_commit_mode = s.op;
  assign o_commit_addr = s.addr;
  assign o_commit_data = s.data;

  default clocking eng_cb @(posedge i_clk);
  endclocking
  default disable iff (i_por_rst);

  mode_frozen_a: assert property (s.busy |=> s.mode == $past(s.mode))
    else $error("mode changed while programming");
  mode_reset_a: assert property (i_rst && !s.busy |=> s.mode == MODE_RESET)
    else $error("mode not cleared by reset");
  strobe_end_a: assert property ($fell(s.busy) |->
    s.commit || $past(s.op) == MODE_RSVD)
    else $error("busy dropped without commit");
  rsvd_noop_a: assert property (i_start && !s.busy &&
    next_s.op == MODE_RSVD |=> s.busy ##1 (!s.busy && !s.commit))
    else $error("reserved mode not a no-op");
  tick_reload_a: assert property (!s.busy && i_start |=>
    s.ticks == mode_ticks(s.op))
    else $error("wrong programming length");
endmodule : eac_prog_engine

/* hw/eac_eeprom_access_controller.sv */
`timescale 1ns/1ps
// Behaviour
// - A read strobe stalls the CPU for four clock cycles.
// - Launching a write stalls the CPU for two clock cycles.
// - Address bits 15..12 ignore writes and read as zero.
// - Twelve-bit linear byte address; software loads it before access.
// - Data byte feeds writes and holds the byte fetched by a read.
// - Control bits 7..6 always read as zero.
// - Mode selects atomic, erase-only, write-only or reserved action.
// - Mode writes are ignored while the program strobe is set.
// - Reset clears the mode to atomic unless programming is busy.
// - Ready interrupt is a level while enabled and strobe is clear.
// - Program strobe starts a write only while the arm bit is set.
// - Hardware clears the arm bit four cycles after software sets it.
// - No programming starts while a flash self-program is busy.
// - Strobe stays set for the whole write and clears at its end.
// - Read strobe fetches the addressed byte within one instruction.
// - During a write, reads are refused and the address is frozen.
// - Programming interval counts 26,368 calibrated oscillator cycles in atomic mode, 13,959 in erase-only or write-only.
module eac_eeprom_access_controller
  import eac_pkg::*;
#(
  parameter int ATOMIC_TICKS = ATOMIC_TICKS_DEF,
  parameter int SPLIT_TICKS = SPLIT_TICKS_DEF
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_por_rst,
  input wire logic [1:0] i_io_sel,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_io_wdata,
  input wire logic i_global_irq_enable,
  input wire logic i_flash_selfprog_busy,
  output logic [7:0] o_io_rdata,
  output logic o_cpu_stall,
  output logic o_ready_irq,
  output logic o_prog_busy
);
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
    logic irq_en;
    logic arm;
    logic [2:0] arm_cnt;
    logic [2:0] stall_cnt;
    logic stall;
    logic [7:0] rdata;
    logic irq;
  } eac_main_type;

  eac_main_type s;
  eac_main_type next_s;
  logic rd_take;
  logic start;
  logic mode_wr;
  logic prog_busy;
  eac_mode_type mode;
  logic [7:0] nv_rd_data;
  logic commit;
  eac_mode_type commit_mode;
  logic [NV_AW-1:0] commit_addr;
  logic [7:0] commit_data;

  // Control register image; the read strobe bit never reads back set
  function automatic logic [7:0] ctrl_image(input eac_mode_type m,
                                            input logic ie,
                                            input logic arm,
                                            input logic busy);
    ctrl_image = {2'b00, m, ie, arm, busy, 1'b0};
  endfunction : ctrl_image

  // Register writes, strobes, arm window and stall timing
  always_comb begin
    next_s = s;
    rd_take = 1'b0;
    start = 1'b0;
    mode_wr = 1'b0;
    if (s.arm) begin
      next_s.arm_cnt = s.arm_cnt - 3'h1;
      if (s.arm_cnt == 3'h1) begin
        next_s.arm = 1'b0;
      end
    end
    if (s.stall_cnt != 3'h0) begin
      next_s.stall_cnt = s.stall_cnt - 3'h1;
    end
    if (i_io_wr) begin
      unique case (i_io_sel)
        REG_ADDR_LOW: begin
          if (!prog_busy) begin
            next_s.addr[7:0] = i_io_wdata;
          end
        end
        REG_ADDR_HIGH: begin
          if (!prog_busy) begin
            next_s.addr[ADDR_W-1:8] = i_io_wdata[ADDR_HI_W-1:0];
          end
        end
        REG_DATA: begin
          // Safe during a write, the engine holds its own copy
          next_s.data = i_io_wdata;
        end
        REG_CTRL: begin
          next_s.irq_en = i_io_wdata[CTRL_IRQEN_BIT];
          mode_wr = 1'b1;
          if (i_io_wdata[CTRL_PROG_BIT]) begin
            if (s.arm && !prog_busy && !i_flash_selfprog_busy) begin
              start = 1'b1;
              next_s.arm = 1'b0;
              next_s.stall_cnt = WRITE_STALL_CYCLES;
            end
          end else if (i_io_wdata[CTRL_ARM_BIT]) begin
            next_s.arm = 1'b1;
            next_s.arm_cnt = ARM_WINDOW_CYCLES;
          end
          if (i_io_wdata[CTRL_READ_BIT] && !prog_busy && !start) begin
            rd_take = 1'b1;
            next_s.data = nv_rd_data;
            next_s.stall_cnt = READ_STALL_CYCLES;
          end
        end
      endcase
    end
    next_s.stall = next_s.stall_cnt != 3'h0;
    if (i_io_rd) begin
      unique case (i_io_sel)
        REG_ADDR_LOW: next_s.rdata = s.addr[7:0];
        REG_ADDR_HIGH: next_s.rdata = {4'h0, s.addr[ADDR_W-1:8]};
        REG_DATA: next_s.rdata = s.data;
        REG_CTRL: next_s.rdata = ctrl_image(mode, s.irq_en, s.arm,
                                            prog_busy);
      endcase
    end
    // Level request, held off for the whole programming interval
    next_s.irq = s.irq_en && i_global_irq_enable && !prog_busy;
  end

  // CPU-side state; address has no defined value, zero is chosen
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  eac_prog_engine #(
    .ATOMIC_TICKS(ATOMIC_TICKS),
    .SPLIT_TICKS(SPLIT_TICKS)
  ) u_engine (
    .i_clk(i_clk),
    .i_por_rst(i_por_rst),
    .i_rst(i_rst),
    .i_start(start),
    .i_mode_wr(mode_wr),
    .i_mode_val(eac_mode_type'(i_io_wdata[CTRL_MODE_LSB+:2])),
    .i_addr(s.addr[NV_AW-1:0]),
    .i_data(s.data),
    .o_busy(prog_busy),
    .o_mode(mode),
    .o_commit(commit),
    .o_commit_mode(commit_mode),
    .o_commit_addr(commit_addr),
    .o_commit_data(commit_data)
  );

  // Addresses above the array alias onto it
  eac_nv_array u_array (
    .i_clk(i_clk),
    .i_commit(commit),
    .i_mode(commit_mode),
    .i_addr(commit_addr),
    .i_data(commit_data),
    .i_rd_addr(s.addr[NV_AW-1:0]),
    .o_rd_data(nv_rd_data)
  );

  assign o_io_rdata = s.rdata;
  assign o_cpu_stall = s.stall;
  assign o_ready_irq = s.irq;
  assign o_prog_busy = prog_busy;

  default clocking main_cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  sequence arm_set_s;
    $rose(s.arm) ##0 (!i_io_wr) [*4];
  endsequence

  // Stall flop rises one edge after the strobe, so the window ends late
  sequence launch_s;
    start ##1 (!i_io_wr) [*3];
  endsequence

  read_stall_a: assert property (rd_take ##1 (!i_io_wr) [*5] |->
    $past(o_cpu_stall, 4) && $past(o_cpu_stall) && !o_cpu_stall)
    else $error("read stall not four cycles");
  write_stall_a: assert property (launch_s |->
    $past(o_cpu_stall, 2) && $past(o_cpu_stall) && !o_cpu_stall)
    else $error("write stall not two cycles");
  addr_high_zero_a: assert property (i_io_rd && i_io_sel == REG_ADDR_HIGH
    |=> o_io_rdata[7:4] == 4'h0)
    else $error("address reserved bits nonzero");
  ctrl_rsvd_zero_a: assert property (i_io_rd && i_io_sel == REG_CTRL
    |=> o_io_rdata[7:6] == 2'b00 && o_io_rdata[CTRL_READ_BIT] == 1'b0)
    else $error("control reserved bits nonzero");
  read_fetch_a: assert property (rd_take |=>
    s.data == $past(nv_rd_data))
    else $error("read did not load data byte");
  irq_level_a: assert property (o_ready_irq == ($past(s.irq_en) &&
    $past(i_global_irq_enable) && !$past(prog_busy)))
    else $error("ready interrupt level wrong");
  arm_expire_a: assert property (arm_set_s |=> !s.arm)
    else $error("arm bit did not expire");
  start_armed_a: assert property (start |-> s.arm &&
    !i_flash_selfprog_busy ##1 prog_busy)
    else $error("write launched without arm");
  addr_frozen_a: assert property (prog_busy && i_io_wr &&
    i_io_sel != REG_CTRL |=> s.addr == $past(s.addr))
    else $error("address changed during write");
  read_refused_a: assert property (prog_busy |-> !rd_take)
    else $error("read accepted during write");
endmodule : eac_eeprom_access_controller

/* sim/tb_eac_eeprom_access_controller.sv */
`timescale 1ns/1ps
module tb_eac_eeprom_access_controller
  import eac_pkg::*;
;
  localparam int AT = 8;
  localparam int ST = 4;
  logic i_clk;
  logic i_rst = 1'b1;
  logic i_por_rst = 1'b1;
  logic [1:0] i_io_sel = 2'h0;
  logic i_io_wr = 1'b0;
  logic i_io_rd = 1'b0;
  logic [7:0] i_io_wdata = 8'h00;
  logic i_global_irq_enable = 1'b0;
  logic i_flash_selfprog_busy = 1'b0;
  logic [7:0] o_io_rdata;
  logic o_cpu_stall;
  logic o_ready_irq;
  logic o_prog_busy;
  int n_mismatch = 0;
  int compares = 0;
  logic [7:0] ie = 8'h00;
  logic [7:0] v;
  int s;
  int b;
  int e;
  // Data per mode and the byte expected in the cell afterwards
  logic [7:0] md [4] = '{8'hA5, 8'h00, 8'h3C, 8'h00};
  logic [7:0] mx [4] = '{8'hA5, 8'hFF, 8'h3C, 8'h3C};

  // Short tick counts keep each programming interval brief
  eac_eeprom_access_controller #(
    .ATOMIC_TICKS(AT),
    .SPLIT_TICKS(ST)
  ) uut (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_por_rst(i_por_rst),
    .i_io_sel(i_io_sel),
    .i_io_wr(i_io_wr),
    .i_io_rd(i_io_rd),
    .i_io_wdata(i_io_wdata),
    .i_global_irq_enable(i_global_irq_enable),
    .i_flash_selfprog_busy(i_flash_selfprog_busy),
    .o_io_rdata(o_io_rdata),
    .o_cpu_stall(o_cpu_stall),
    .o_ready_irq(o_ready_irq),
    .o_prog_busy(o_prog_busy)
  );

  // 25 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  // One register write, a single-cycle strobe
  task automatic wr(input logic [1:0] sel, input logic [7:0] d);
    @(posedge i_clk);
    i_io_sel <= sel;
    i_io_wdata <= d;
    i_io_wr <= 1'b1;
    @(posedge i_clk);
    i_io_wr <= 1'b0;
  endtask : wr

  // One register read; data is registered, so sample an edge later
  task automatic rd(input logic [1:0] sel, output logic [7:0] d);
    @(posedge i_clk);
    i_io_sel <= sel;
    i_io_rd <= 1'b1;
    @(posedge i_clk);
    i_io_rd <= 1'b0;
    @(posedge i_clk);
    #1 d = o_io_rdata;
  endtask : rd

  // Counts stall and busy cycles until busy falls or the limit runs out;
  // the first sample falls in the cycle right after the strobe edge
  task automatic count(output int sc, output int bc);
    sc = 0;
    bc = 0;
    for (int k = 0; k < 40; k++) begin
      #1;
      if (o_cpu_stall === 1'b1) sc++;
      if (o_prog_busy === 1'b1) bc++;
      else if (bc > 0) break;
      @(posedge i_clk);
    end
  endtask : count

  // Address, data, arm, then strobe two cycles after the arm
  task automatic launch(input logic [11:0] a, input logic [7:0] d,
                        input logic [1:0] m);
    wr(REG_ADDR_LOW, a[7:0]);
    wr(REG_ADDR_HIGH, {4'h0, a[11:8]});
    wr(REG_DATA, d);
    wr(REG_CTRL, 8'h04 | ie);
    wr(REG_CTRL, 8'h02 | ie | {2'b00, m, 4'h0});
  endtask : launch

  // Read strobe, stall length, then the data byte
  task automatic fetch(output logic [7:0] d);
    wr(REG_CTRL, 8'h01 | ie);
    count(s, b);
    check(8'(s), 8'h04);
    rd(REG_DATA, d);
  endtask : fetch

  // CPU reset only; the engine reset stays low
  task automatic rst_pulse();
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
  endtask : rst_pulse

  task automatic done(input string name);
    $display("test %0s finished", name);
  endtask : done

  // Watchdog, far beyond the expected run of about 600 cycles
  initial begin
    #(40 * 6000);
    n_mismatch++;
    print_verdict();
  end

  initial begin
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    i_por_rst <= 1'b0;
    // Reset values, reserved bits, interrupt gating
    rd(REG_ADDR_LOW, v);
    check(v, 8'h00);
    rd(REG_DATA, v);
    check(v, 8'h00);
    rd(REG_CTRL, v);
    check(v, 8'h00);
    wr(REG_ADDR_HIGH, 8'hFF);
    rd(REG_ADDR_HIGH, v);
    check(v, 8'h0F);
    wr(REG_CTRL, 8'hC8);
    rd(REG_CTRL, v);
    check(v, 8'h08);
    check({7'h00, o_ready_irq}, 8'h00);
    @(posedge i_clk);
    i_global_irq_enable <= 1'b1;
    repeat (2) @(posedge i_clk);
    #1 check({7'h00, o_ready_irq}, 8'h01);
    done("registers");
    // Every mode on one cell: stall, interval and resulting byte
    for (int k = 0; k < 4; k++) begin
      launch(12'h006, md[k], k[1:0]);
      count(s, b);
      e = (k == 0) ? AT * CLK_KHZ / RC_KHZ : ST * CLK_KHZ / RC_KHZ;
      if (k == 3) e = 2;
      check(8'(s), 8'h02);
      check(8'(b >= e - 1 && b <= e + 2), 8'h01);
      fetch(v);
      check(v, mx[k]);
    end
    done("modes");
    // Arm window expiry and refused launches
    wr(REG_CTRL, 8'h04);
    rd(REG_CTRL, v);
    check(v, 8'h04);
    repeat (3) @(posedge i_clk);
    rd(REG_CTRL, v);
    check(v, 8'h00);
    wr(REG_CTRL, 8'h02);
    count(s, b);
    check(8'(b), 8'h00);
    @(posedge i_clk);
    i_flash_selfprog_busy <= 1'b1;
    launch(12'h006, 8'h00, 2'h0);
    count(s, b);
    check(8'(b), 8'h00);
    @(posedge i_clk);
    i_flash_selfprog_busy <= 1'b0;
    fetch(v);
    check(v, 8'h3C);
    done("arming");
    // Traffic while busy: address, mode and read strobe are refused
    ie = 8'h08;
    launch(12'h006, 8'h5A, 2'h2);
    wr(REG_ADDR_LOW, 8'h99);
    rd(REG_CTRL, v);
    check(v, 8'h2A);
    check({7'h00, o_ready_irq}, 8'h00);
    wr(REG_DATA, 8'h77);
    wr(REG_CTRL, 8'h39);
    count(s, b);
    check(8'(s), 8'h00);
    @(posedge i_clk);
    #1 check({7'h00, o_ready_irq}, 8'h01);
    rd(REG_CTRL, v);
    check(v, 8'h28);
    rd(REG_DATA, v);
    check(v, 8'h77);
    rd(REG_ADDR_LOW, v);
    check(v, 8'h06);
    fetch(v);
    check(v, 8'h18);
    ie = 8'h00;
    done("busy");
    // A CPU reset in mid-write keeps the mode and lets the write finish
    launch(12'h006, 8'h0F, 2'h2);
    rst_pulse();
    #1 check({7'h00, o_prog_busy}, 8'h01);
    count(s, b);
    rd(REG_CTRL, v);
    check(v, 8'h20);
    rst_pulse();
    rd(REG_CTRL, v);
    check(v, 8'h00);
    wr(REG_ADDR_LOW, 8'h06);
    wr(REG_ADDR_HIGH, 8'h00);
    fetch(v);
    check(v, 8'h08);
    done("reset");
    print_verdict();
  end
endmodule : tb_eac_eeprom_access_controller
